// ==== timer_port_pkg.sv ====
// Constants for the timer host port and index pointer.
package timer_port_pkg;
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;
	localparam int NUM_CNT = 5;
	localparam int PTR_W = 6;
	localparam logic [2:0] GRP_CTRL = 3'h7;
	localparam logic [2:0] GRP_FIRST = 3'h1;
	localparam logic [2:0] GRP_LAST = 3'h5;
	localparam logic [1:0] ELEM_MODE = 2'h0;
	localparam logic [1:0] ELEM_LAST = 2'h2;
	localparam logic [1:0] ELEM_HOLD = 2'h3;
	// Control group elements.
	localparam logic [1:0] ELEM_ALARM1 = 2'h0;
	localparam logic [1:0] ELEM_MASTER = 2'h1;
	localparam logic [1:0] ELEM_ALARM2 = 2'h2;
	localparam int MM_BUS_WIDTH = 13;
	localparam int MM_SEQ_DIS = 14;
	localparam logic [15:0] MM_RESET = 16'h0000;
	// Command encodings: opcode in bits 7:5, counter select in bits 4:0.
	localparam logic [2:0] OP_PTR = 3'h0;
	localparam logic [2:0] OP_ARM = 3'h1;
	localparam logic [2:0] OP_LOAD = 3'h2;
	localparam logic [2:0] OP_LOADARM = 3'h3;
	localparam logic [2:0] OP_DISSAVE = 3'h4;
	localparam logic [2:0] OP_SAVE = 3'h5;
	localparam logic [2:0] OP_DISARM = 3'h6;
	localparam logic [2:0] OP_SPECIAL = 3'h7;
	localparam logic [2:0] TOP_ONES = 3'h7;
	localparam int STAT_BYTE = 0;
	localparam logic [4:0] SEL_NONE = 5'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage : timer_port_pkg

// ==== timer_reg_bank.sv ====
// Register memory for the counter groups: mode, load and hold per counter.
`timescale 1ns/1ps
module timer_reg_bank (
	// Clock and control.
	input  wire logic        clock,
	input  wire logic        clkEn,
	// Read port with registered data.
	input  wire logic [3:0]  rdAddr,
	output logic      [15:0] rdData,
	// Write port.
	input  wire logic        wrEn,
	input  wire logic [3:0]  wrAddr,
	input  wire logic [15:0] wrData
);
	logic [15:0] mem [0:15];

	always_ff @(posedge clock) begin
		if (clkEn) begin
			if (wrEn) begin
				mem[wrAddr] <= wrData;
			end
			rdData <= mem[rdAddr];
		end
	end
endmodule : timer_reg_bank

// ==== timer_host_port_pointer.sv ====
// Host port front end: control/data ports, index pointer, basic counter commands.
`timescale 1ns/1ps
module timer_host_port_pointer (
	// Clock, reset, enable.
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        clkEn,
	// Host bus pins.
	input  wire logic        chipSel_n,
	input  wire logic        rdStrobe_n,
	input  wire logic        wrStrobe_n,
	input  wire logic        portSel,
	input  wire logic [15:0] dataIn,
	output logic      [15:0] dataOut,
	output logic      [15:0] dataOe,
	// Counter side.
	input  wire logic [4:0]  countTick,
	input  wire logic [4:0]  counterOut,
	output logic      [4:0]  armed,
	output logic      [15:0] cnt1,
	output logic      [15:0] cnt2,
	output logic      [15:0] cnt3,
	output logic      [15:0] cnt4,
	output logic      [15:0] cnt5,
	output logic      [15:0] masterMode
);
	typedef enum logic [1:0] {
		IDLE  = 2'b00,
		RDACT = 2'b01,
		WRACT = 2'b10,
		FETCH = 2'b11
	} phase_e;

	typedef struct packed {
		logic [2:0]  csSync;
		logic [2:0]  rdSync;
		logic [2:0]  wrSync;
		logic [1:0]  cdSync;
		logic [31:0] dSync;
		phase_e      phase;
		logic        fetchWait;
		logic        isCtrl;
		logic [15:0] latchIn;
		logic [2:0]  grp;
		logic [1:0]  elem;
		logic        bytePtr;
		logic [15:0] mm;
		logic [15:0] alarm1;
		logic [15:0] alarm2;
		logic [15:0] prefetch;
		logic [4:0]  arm;
		logic [4:0][15:0] cnt;
		logic [15:0] dOut;
		logic [15:0] dOe;
		logic [4:0]  saveSel;
		logic        saveGo;
		logic [4:0]  loadSel;
		logic        loadGo;
		logic [2:0]  opIdx;
	} state_s;

	state_s st_r;
	state_s st_nxt;
	logic [15:0] bankRd;
	logic        bankWe;
	logic [3:0]  bankWa;
	logic [15:0] bankWd;
	logic [3:0]  bankRa;
	logic [15:0] cur;
	logic        adv;

	// Mode, load and hold rows of five words each; the hold-cycle code shares the hold row.
	function automatic logic [3:0] bankAddr(input logic [2:0] g, input logic [1:0] e);
		logic [1:0] r;
		r = (e == timer_port_pkg::ELEM_HOLD) ? timer_port_pkg::ELEM_LAST : e;
		bankAddr = {r, 2'b00} + {2'b00, r} + {1'b0, g - 3'h1};
	endfunction : bankAddr

	function automatic logic [7:0] statusByte(input logic bp, input logic [4:0] o);
		statusByte = {2'b00, o, bp};
	endfunction : statusByte

	timer_reg_bank u_bank (
		.clock  (clock),
		.clkEn  (clkEn),
		.rdAddr (bankRa),
		.rdData (bankRd),
		.wrEn   (bankWe),
		.wrAddr (bankWa),
		.wrData (bankWd)
	);

	logic csAct;
	logic rdAct;
	logic wrAct;
	logic wide;
	assign csAct = ~st_r.csSync[1];
	assign rdAct = csAct & ~st_r.rdSync[1];
	assign wrAct = csAct & ~st_r.wrSync[1];
	assign wide = st_r.mm[timer_port_pkg::MM_BUS_WIDTH];

	always_comb begin
		logic [15:0] wv;
		cur = 16'h0000;
		wv = 16'h0000;
		adv = 1'b0;
		st_nxt = st_r;
		bankWe = 1'b0;
		bankWa = bankAddr(st_r.grp, st_r.elem);
		bankWd = 16'h0000;
		bankRa = bankAddr(st_r.grp, st_r.elem);
		st_nxt.csSync = {st_r.csSync[1:0], chipSel_n};
		st_nxt.rdSync = {st_r.rdSync[1:0], rdStrobe_n};
		st_nxt.wrSync = {st_r.wrSync[1:0], wrStrobe_n};
		st_nxt.cdSync = {st_r.cdSync[0], portSel};
		st_nxt.dSync = {st_r.dSync[15:0], dataIn};
		// The load pacing flag is kept through the fetch so its first bank read lines up.
		st_nxt.saveGo = 1'b0;
		for (int i = 0; i < timer_port_pkg::NUM_CNT; i++) begin
			if (st_r.arm[i] && countTick[i]) begin
				st_nxt.cnt[i] = st_r.cnt[i] - 16'h0001;
			end
		end
		// Selected value of the current data-port location.
		if (st_r.grp == timer_port_pkg::GRP_CTRL) begin
			unique case (st_r.elem)
				timer_port_pkg::ELEM_ALARM1: cur = st_r.alarm1;
				timer_port_pkg::ELEM_MASTER: cur = st_r.mm;
				timer_port_pkg::ELEM_ALARM2: cur = st_r.alarm2;
				timer_port_pkg::ELEM_HOLD:
					cur = {8'h00, statusByte(st_r.bytePtr, counterOut)};
			endcase
		end else begin
			cur = bankRd;
		end
		unique case (st_r.phase)
			IDLE: begin
				st_nxt.dOe = 16'h0000;
				if (rdAct) begin
					st_nxt.phase = RDACT;
					st_nxt.isCtrl = st_r.cdSync[1];
					if (st_r.cdSync[1]) begin
						st_nxt.dOut = {8'h00, statusByte(st_r.bytePtr, counterOut)};
						st_nxt.dOe = 16'h00FF;
					end else if (wide) begin
						st_nxt.dOut = st_r.prefetch;
						st_nxt.dOe = 16'hFFFF;
					end else begin
						st_nxt.dOut = {8'h00, st_r.bytePtr ? st_r.prefetch[7:0]
							: st_r.prefetch[15:8]};
						st_nxt.dOe = 16'h00FF;
					end
				end else if (wrAct) begin
					st_nxt.phase = WRACT;
					st_nxt.isCtrl = st_r.cdSync[1];
				end
			end
			RDACT: begin
				if (!rdAct) begin
					st_nxt.dOe = 16'h0000;
					st_nxt.phase = st_r.isCtrl ? IDLE : FETCH;
					adv = ~st_r.isCtrl;
				end
			end
			WRACT: begin
				st_nxt.latchIn = st_r.dSync[31:16];
				if (!wrAct) begin
					st_nxt.phase = FETCH;
					if (st_r.isCtrl) begin
						unique case (st_r.latchIn[7:5])
							timer_port_pkg::OP_PTR: begin
								st_nxt.grp = st_r.latchIn[2:0];
								st_nxt.elem = st_r.latchIn[4:3];
								st_nxt.bytePtr = 1'b1;
							end
							timer_port_pkg::OP_ARM:
								st_nxt.arm = st_r.arm | st_r.latchIn[4:0];
							timer_port_pkg::OP_LOAD: begin
								st_nxt.loadSel = st_r.latchIn[4:0];
								st_nxt.loadGo = 1'b1;
								st_nxt.opIdx = 3'h0;
							end
							timer_port_pkg::OP_LOADARM: begin
								st_nxt.loadSel = st_r.latchIn[4:0];
								st_nxt.loadGo = 1'b1;
								st_nxt.opIdx = 3'h0;
								st_nxt.arm = st_r.arm | st_r.latchIn[4:0];
							end
							timer_port_pkg::OP_DISSAVE: begin
								st_nxt.arm = st_r.arm & ~st_r.latchIn[4:0];
								st_nxt.saveSel = st_r.latchIn[4:0];
								st_nxt.saveGo = 1'b1;
								st_nxt.opIdx = 3'h0;
							end
							timer_port_pkg::OP_SAVE: begin
								st_nxt.saveSel = st_r.latchIn[4:0];
								st_nxt.saveGo = 1'b1;
								st_nxt.opIdx = 3'h0;
							end
							timer_port_pkg::OP_DISARM:
								st_nxt.arm = st_r.arm & ~st_r.latchIn[4:0];
							timer_port_pkg::OP_SPECIAL:
								if (st_r.latchIn[4:0] == 5'h17
									&& st_r.dSync[31:29] == timer_port_pkg::TOP_ONES) begin
									st_nxt.mm[timer_port_pkg::MM_BUS_WIDTH] = 1'b1;
								end else if (st_r.latchIn[4:0] == 5'h0F) begin
									st_nxt.mm[timer_port_pkg::MM_BUS_WIDTH] = 1'b0;
								end
						endcase
					end else begin
						if (wide) begin
							wv = st_r.latchIn;
						end else if (st_r.bytePtr) begin
							wv = {cur[15:8], st_r.latchIn[7:0]};
						end else begin
							wv = {st_r.latchIn[7:0], cur[7:0]};
						end
						if (st_r.grp == timer_port_pkg::GRP_CTRL) begin
							unique case (st_r.elem)
								timer_port_pkg::ELEM_ALARM1: st_nxt.alarm1 = wv;
								timer_port_pkg::ELEM_MASTER: st_nxt.mm = wv;
								timer_port_pkg::ELEM_ALARM2: st_nxt.alarm2 = wv;
								timer_port_pkg::ELEM_HOLD: ;
							endcase
						end else begin
							bankWe = 1'b1;
							bankWd = wv;
						end
						adv = 1'b1;
					end
				end
			end
			FETCH: begin
				// The bank read is registered, so the new pointer's word lands one cycle late.
				st_nxt.fetchWait = ~st_r.fetchWait;
				if (st_r.fetchWait) begin
					st_nxt.prefetch = cur;
					st_nxt.phase = IDLE;
				end
			end
		endcase
		// Index pointer sequencing after a data-port transfer.
		if (adv) begin
			if (!wide) begin
				st_nxt.bytePtr = ~st_r.bytePtr;
			end else begin
				st_nxt.bytePtr = 1'b1;
			end
			if (!st_r.mm[timer_port_pkg::MM_SEQ_DIS] && (wide || !st_r.bytePtr)) begin
				if (st_r.grp == timer_port_pkg::GRP_CTRL) begin
					if (st_r.elem != timer_port_pkg::ELEM_HOLD) begin
						st_nxt.elem = (st_r.elem == timer_port_pkg::ELEM_LAST)
							? timer_port_pkg::ELEM_MODE : st_r.elem + 2'h1;
					end
				end else if (st_r.elem == timer_port_pkg::ELEM_HOLD) begin
					st_nxt.grp = (st_r.grp >= timer_port_pkg::GRP_LAST)
						? timer_port_pkg::GRP_FIRST : st_r.grp + 3'h1;
				end else if (st_r.elem == timer_port_pkg::ELEM_LAST) begin
					st_nxt.elem = timer_port_pkg::ELEM_MODE;
					st_nxt.grp = (st_r.grp >= timer_port_pkg::GRP_LAST)
						? timer_port_pkg::GRP_FIRST : st_r.grp + 3'h1;
				end else begin
					st_nxt.elem = st_r.elem + 2'h1;
				end
			end
		end
		// Save walks the counters one per cycle, load one per two cycles (address, then capture), through the bank port.
		if (st_r.phase == FETCH) begin
			bankRa = bankAddr(st_r.grp, st_r.elem);
		end else if (st_r.loadSel != timer_port_pkg::SEL_NONE) begin
			bankRa = bankAddr(st_r.opIdx + 3'h1, 2'h1);
		end
		if (st_r.saveSel != timer_port_pkg::SEL_NONE && !bankWe) begin
			if (st_r.saveSel[st_r.opIdx]) begin
				bankWe = 1'b1;
				bankWa = bankAddr(st_r.opIdx + 3'h1, timer_port_pkg::ELEM_LAST);
				bankWd = st_r.cnt[st_r.opIdx];
			end
			st_nxt.saveSel[st_r.opIdx] = 1'b0;
			st_nxt.opIdx = (st_r.opIdx == 3'h4) ? 3'h0 : st_r.opIdx + 3'h1;
		end else if (st_r.loadSel != timer_port_pkg::SEL_NONE && st_r.phase != FETCH) begin
			if (st_r.loadGo) begin
				st_nxt.loadGo = 1'b0;
			end else begin
				if (st_r.loadSel[st_r.opIdx]) begin
					st_nxt.cnt[st_r.opIdx] = bankRd;
				end
				st_nxt.loadSel[st_r.opIdx] = 1'b0;
				st_nxt.opIdx = (st_r.opIdx == 3'h4) ? 3'h0 : st_r.opIdx + 3'h1;
				st_nxt.loadGo = 1'b1;
			end
		end
		if (!rst_n) begin
			st_nxt = '0;
			st_nxt.csSync = 3'h7;
			st_nxt.rdSync = 3'h7;
			st_nxt.wrSync = 3'h7;
			st_nxt.phase = IDLE;
			st_nxt.mm = timer_port_pkg::MM_RESET;
			st_nxt.bytePtr = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (clkEn || !rst_n) begin
			st_r <= st_nxt;
		end
	end

	always_comb begin
		dataOut = st_r.dOut;
		dataOe = st_r.dOe;
		armed = st_r.arm;
		cnt1 = st_r.cnt[0];
		cnt2 = st_r.cnt[1];
		cnt3 = st_r.cnt[2];
		cnt4 = st_r.cnt[3];
		cnt5 = st_r.cnt[4];
		masterMode = st_r.mm;
	end

	ptr_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
		(adv && clkEn && st_r.grp == timer_port_pkg::GRP_CTRL
			&& st_r.elem == timer_port_pkg::ELEM_HOLD)
		|=> ($stable(st_r.grp) && $stable(st_r.elem))
		) else $error("status location advanced");
	grp_range_a: assert property (@(posedge clock) disable iff (!rst_n)
		(adv && st_r.grp != 3'h7 && st_r.grp != 3'h0) |=> (st_r.grp inside {[3'h1:3'h5]})
		) else $error("group left counter set");
	cs_ignore_a: assert property (@(posedge clock) disable iff (!rst_n)
		(st_r.phase == IDLE && !csAct && clkEn) |=> st_r.phase == IDLE
		) else $error("strobe taken without chip select");
	wide_byte_a: assert property (@(posedge clock) disable iff (!rst_n)
		(wide && adv) |=> st_r.bytePtr
		) else $error("byte flag cleared in wide mode");
	seq_off_a: assert property (@(posedge clock) disable iff (!rst_n)
		(adv && st_r.mm[timer_port_pkg::MM_SEQ_DIS] && clkEn)
		|=> ($stable(st_r.grp) && $stable(st_r.elem))
		) else $error("pointer advanced with sequencing off");
	ctrl_width_a: assert property (@(posedge clock) disable iff (!rst_n)
		(st_r.isCtrl && st_r.phase == RDACT) |-> st_r.dOe[15:8] == 8'h00
		) else $error("control read drove high lines");
	narrow_oe_a: assert property (@(posedge clock) disable iff (!rst_n)
		!wide |-> st_r.dOe[15:8] == 8'h00
		) else $error("high lines driven in narrow mode");
	prefetch_a: assert property (@(posedge clock) disable iff (!rst_n)
		(st_r.phase == FETCH && st_r.fetchWait && clkEn) |=> st_r.prefetch == $past(cur)
		) else $error("prefetch missed");
	rd_cov: cover property (@(posedge clock) st_r.phase == RDACT);
	wr_cov: cover property (@(posedge clock) st_r.phase == WRACT && !st_r.isCtrl);
	wrap_cov: cover property (@(posedge clock) adv && st_r.elem == 2'h2);
endmodule : timer_host_port_pointer

// ==== host_bus_model.sv ====
// Host processor model that runs strobed read and write cycles on the timer bus pins.
`timescale 1ns/1ps
module host_bus_model (
	// Clock.
	input  wire logic        clock,
	// Bus pins.
	output logic             chipSel_n,
	output logic             rdStrobe_n,
	output logic             wrStrobe_n,
	output logic             portSel,
	output logic      [15:0] dataIn,
	input  wire logic [15:0] dataOut,
	input  wire logic [15:0] dataOe
);
	initial begin
		chipSel_n  = 1'b1;
		rdStrobe_n = 1'b1;
		wrStrobe_n = 1'b1;
		portSel    = 1'b0;
		dataIn     = 16'hffff;
	end

	// One strobe at a time, held six cycles, then a long gap so prefetch and commands finish.
	task automatic cycle(input logic sel, input logic wr, input logic cd,
			input logic [15:0] d, output logic [15:0] q, output logic [15:0] oe);
		@(posedge clock);
		chipSel_n <= ~sel;
		portSel   <= cd;
		if (wr) begin
			dataIn <= cd ? {8'hff, d[7:0]} : d;
		end
		rdStrobe_n <= wr;
		wrStrobe_n <= ~wr;
		repeat (6) @(posedge clock);
		q  = dataOut;
		oe = dataOe;
		rdStrobe_n <= 1'b1;
		wrStrobe_n <= 1'b1;
		repeat (4) @(posedge clock);
		chipSel_n <= 1'b1;
		// Released lines show the inverse so a stale value cannot pass for a driven one.
		dataIn <= ~dataIn;
		repeat (12) @(posedge clock);
	endtask : cycle
endmodule : host_bus_model

// ==== tb_top.sv ====
// Self-checking bench for the timer host port against a reference model.
`timescale 1ns/1ps
module tb_top;
	logic        clock;
	logic        rst_n;
	logic        clkEn;
	logic        chipSel_n;
	logic        rdStrobe_n;
	logic        wrStrobe_n;
	logic        portSel;
	logic [15:0] dataIn;
	logic [15:0] dataOut;
	logic [15:0] dataOe;
	logic [4:0]  countTick;
	logic [4:0]  counterOut;
	logic [4:0]  armed;
	logic [15:0] cnt [1:5];
	logic [15:0] masterMode;
	logic [15:0] rf [0:31];
	logic [15:0] mc [1:5];
	logic [4:0]  ma;
	logic [15:0] mm;
	logic [2:0]  grp;
	logic [1:0]  elem;
	logic        bp;
	logic [15:0] q;
	logic [15:0] oe;
	int          errorCnt;
	int          checkCount;

	timer_host_port_pointer u_dut (
		.clock      (clock),
		.rst_n      (rst_n),
		.clkEn      (clkEn),
		.chipSel_n  (chipSel_n),
		.rdStrobe_n (rdStrobe_n),
		.wrStrobe_n (wrStrobe_n),
		.portSel    (portSel),
		.dataIn     (dataIn),
		.dataOut    (dataOut),
		.dataOe     (dataOe),
		.countTick  (countTick),
		.counterOut (counterOut),
		.armed      (armed),
		.cnt1       (cnt[1]),
		.cnt2       (cnt[2]),
		.cnt3       (cnt[3]),
		.cnt4       (cnt[4]),
		.cnt5       (cnt[5]),
		.masterMode (masterMode)
	);

	host_bus_model u_host (
		.clock      (clock),
		.chipSel_n  (chipSel_n),
		.rdStrobe_n (rdStrobe_n),
		.wrStrobe_n (wrStrobe_n),
		.portSel    (portSel),
		.dataIn     (dataIn),
		.dataOut    (dataOut),
		.dataOe     (dataOe)
	);

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checkCount++;
		if (g !== e) begin
			errorCnt++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic results;
		if (errorCnt == 0 && checkCount > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : results

	task automatic cwr(input logic [7:0] c);
		logic [2:0] op;
		op = c[7:5];
		u_host.cycle(1'b1, 1'b1, 1'b1, {8'h00, c}, q, oe);
		if (op == 3'h0) begin
			grp  = c[2:0];
			elem = c[4:3];
			bp   = 1'b1;
		end
		if (op == 3'h7 && c[4:0] == 5'h17) mm[13] = 1'b1;
		if (op == 3'h7 && c[4:0] == 5'h0f) mm[13] = 1'b0;
		if (op == 3'h7) rf[5'h1d] = mm;
		for (int i = 1; i <= 5; i++) begin
			if (c[i-1] && (op == 3'h1 || op == 3'h3)) ma[i-1] = 1'b1;
			if (c[i-1] && (op == 3'h4 || op == 3'h6)) ma[i-1] = 1'b0;
			if (c[i-1] && (op == 3'h2 || op == 3'h3)) mc[i] = rf[{i[2:0], 2'h1}];
			if (c[i-1] && (op == 3'h4 || op == 3'h5)) rf[{i[2:0], 2'h2}] = mc[i];
		end
	endtask : cwr

	task automatic crd;
		u_host.cycle(1'b1, 1'b0, 1'b1, 16'h0000, q, oe);
		chk("status", {8'h00, 2'b00, counterOut, bp}, {8'h00, q[7:0]});
		chk("status enable", 16'h00ff, oe);
	endtask : crd

	// One data-port unit: a byte on an 8-bit bus, a word on a 16-bit bus.
	task automatic dx(input logic wr, input logic [15:0] v);
		logic [4:0]  k;
		logic [15:0] e;
		k = {grp, (grp != 3'h7 && elem == 2'h3) ? 2'h2 : elem};
		u_host.cycle(1'b1, wr, 1'b0, v, q, oe);
		if (wr && mm[13]) rf[k] = v;
		else if (wr && bp) rf[k][7:0] = v[7:0];
		else if (wr) rf[k][15:8] = v[7:0];
		e = (k == 5'h1f) ? {8'h00, 2'b00, counterOut, bp} : rf[k];
		if (!wr && mm[13]) chk("data word", e, q);
		if (!wr && !mm[13]) chk("data byte", {8'h00, bp ? e[7:0] : e[15:8]}, {8'h00, q[7:0]});
		if (!wr) chk("data enable", mm[13] ? 16'hffff : 16'h00ff, oe);
		bp = mm[13] ? 1'b1 : ~bp;
		if (!mm[14] && bp) begin
			if (grp == 3'h7 && elem != 2'h3) elem = (elem == 2'h2) ? 2'h0 : elem + 2'h1;
			else if (grp != 3'h7) begin
				if (elem[1]) grp = (grp == 3'h5) ? 3'h1 : grp + 3'h1;
				if (elem != 2'h3) elem = (elem == 2'h2) ? 2'h0 : elem + 2'h1;
			end
		end
		if (wr && k == 5'h1d) mm = rf[k];
	endtask : dx

	task automatic cst;
		chk("armed", {11'h0, ma}, {11'h0, armed});
		for (int i = 1; i <= 5; i++) chk("counter", mc[i], cnt[i]);
		chk("master mode", mm, masterMode);
	endtask : cst

	task automatic tick;
		logic [4:0] t;
		t = 5'($urandom);
		countTick <= t;
		repeat (3) @(posedge clock);
		countTick <= 5'h00;
		for (int i = 1; i <= 5; i++) if (t[i-1] && ma[i-1]) mc[i] = mc[i] - 16'h0003;
		repeat (3) @(posedge clock);
	endtask : tick

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	initial begin
		repeat (60000) @(posedge clock);
		errorCnt++;
		results;
	end

	initial begin
		rst_n      = 1'b0;
		clkEn      = 1'b1;
		countTick  = 5'h00;
		counterOut = 5'h00;
		errorCnt   = 0;
		checkCount = 0;
		ma         = 5'h00;
		mm         = 16'h0000;
		grp        = 3'h0;
		elem       = 2'h0;
		bp         = 1'b1;
		for (int i = 1; i <= 5; i++) mc[i] = 16'h0000;
		for (int i = 0; i < 32; i++) rf[i] = 16'h0000;
		void'($urandom(92734));
		repeat (10) @(posedge clock);
		rst_n      <= 1'b1;
		counterOut <= 5'($urandom);
		@(posedge clock);
		chk("idle enable", 16'h0000, dataOe);
		cst;
		crd;
		cwr(8'h01);
		dx(1'b1, 16'($urandom));
		crd;
		repeat (31) dx(1'b1, 16'($urandom));
		cwr(8'h07);
		repeat (8) dx(1'b1, 16'($urandom) & 16'h9f9f);
		repeat (6) begin
			cwr({3'h0, 2'($urandom), 3'($urandom_range(5, 1))});
			repeat (6) dx(1'b0, 16'h0000);
		end
		cwr(8'h19);
		repeat (12) dx(1'b0, 16'h0000);
		cwr(8'h07);
		repeat (8) dx(1'b0, 16'h0000);
		cwr(8'h1f);
		dx(1'b0, 16'h0000);
		u_host.cycle(1'b0, 1'b1, 1'b1, 16'h003f, q, oe);
		cst;
		repeat (16) begin
			cwr({3'($urandom_range(6, 1)), 5'($urandom)});
			tick;
			cst;
		end
		cwr(8'h19);
		repeat (10) dx(1'b0, 16'h0000);
		cwr(8'h0f);
		dx(1'b1, 16'h0000);
		dx(1'b1, 16'h0040);
		cst;
		cwr(8'h01);
		repeat (4) dx(1'b1, 16'($urandom));
		repeat (4) dx(1'b0, 16'h0000);
		cwr(8'h09);
		repeat (2) dx(1'b0, 16'h0000);
		cwr(8'h0f);
		dx(1'b1, 16'h0000);
		dx(1'b1, 16'h0020);
		cst;
		cwr(8'h01);
		repeat (6) dx(1'b1, 16'($urandom));
		cwr(8'h01);
		repeat (6) dx(1'b0, 16'h0000);
		cwr(8'hef);
		cst;
		cwr(8'h01);
		repeat (2) dx(1'b0, 16'h0000);
		cwr(8'hf7);
		cst;
		crd;
		results;
	end
endmodule : tb_top
